// [rtl/cssc_bridge.sv]
`timescale 1ns/10ps
`include "cssc_regs.svh"
// One H-bridge: state pos/neg maps to its switch pairs, blanked when off
module cssc_bridge
    import cssc_pkg::*;
(
    // Control
    input  wire logic drive_on,
    input  wire logic state_neg,
    // Switches
    output logic      hs_pos,
    output logic      ls_pos,
    output logic      hs_neg,
    output logic      ls_neg
);
    // Only diagonal pairs are ever on; a leg never conducts shoot-through
    assign hs_pos = drive_on & ~state_neg;
    assign ls_pos = drive_on & ~state_neg;
    assign hs_neg = drive_on & state_neg;
    assign ls_neg = drive_on & state_neg;
endmodule : cssc_bridge

// [rtl/cssc_ctrl.sv]
`timescale 1ns/10ps
`include "cssc_regs.svh"
// Operation
// - Mode bits choose two H-bridges or eight stages; bridges after reset.
// - Low-side pairs may run parallel; host keeps them equal, no check here.
// - Each low-side pair's controls arrive together in one register write.
// - Crank hold keeps b1_hs_pos, b2_hs_neg on after reset fall for hold time.
// - Hold interval between reset fall and forced off lies within 400..800 ms.
// - Each held high-side stage has its own hold-enable bit.
// - Any hold-enable set forces independent stage mode.
// - Bridge mode offers full H-bridges only, no half-bridges.
// - Bridge mode with enable low keeps all bridge switches off.
// - Enabled, only a 0-to-1 strobe write steps; strobe 0 holds outputs.
// - Steps walk bridge states through the cycle chosen by direction.
// - After power-on both bridges sit in state pos.
// - Bridge mode never turns on high and low side of one leg together.
// - Direction and strobe in one frame: step uses previous direction.
// - Enable and strobe in one frame: act on enable, ignore strobe.
// - Position kept in a 10-bit counter split into two 5-bit halves.
// - Counter holds 512 after power-up.
// - Count up per step when direction 1, down when direction 0.
// - Counter saturates at max and min until reversed.
// - Each half carries two extra step-check bits.
// - Power-on and software reset return counter to initial value.
// - Parallel arrangements come from config register seven and ten fields.
module cssc_ctrl
    import cssc_pkg::*;
#(
    parameter int unsigned HOLD_CYC = `CSSC_HOLD_CYC
)(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       soft_reset,
    // Frame write port: one pulse per received control frame
    input  wire logic       frame_wr,
    input  wire logic       wr_ctrl,
    input  wire logic       wr_enable,
    input  wire logic       wr_direction,
    input  wire logic       wr_strobe,
    input  wire logic       wr_indep,
    input  wire logic [7:0] wr_indep_on,
    input  wire logic       wr_mode,
    input  wire logic [1:0] wr_bridge_mode_select,
    input  wire logic       wr_cfg7,
    input  wire logic       wr_hold_enable_b1_high_pos,
    input  wire logic       wr_hold_enable_b2_high_neg,
    input  wire logic [1:0] wr_cfg7_ls_parallel,
    input  wire logic       wr_cfg10,
    input  wire logic [1:0] wr_cfg10_hs_parallel,
    // Reset line of the host (falling edge starts crank hold)
    input  wire logic       host_reset_line,
    // Switch outputs
    output logic            b1_hs_pos,
    output logic            b1_ls_neg,
    output logic            b1_hs_neg,
    output logic            b1_ls_pos,
    output logic            b2_hs_neg,
    output logic            b2_hs_pos,
    output logic            b2_ls_pos,
    output logic            b2_ls_neg,
    // Status
    output logic            bridge_active,
    output logic            hold_active,
    output logic [1:0]      ls_parallel,
    output logic [1:0]      hs_parallel,
    output logic [6:0]      step_count_high,
    output logic [6:0]      step_count_low
);

    // ==========================================================
    // Configuration
    logic [1:0]  mode_ff;
    logic        hold_b1_ff;
    logic        hold_b2_ff;
    logic [1:0]  lspar_ff;
    logic [1:0]  hspar_ff;
    logic        enable_ff;
    logic        dir_ff;
    logic        strobe_ff;
    logic [7:0]  indep_ff;
    logic        rst_line_ff;
    logic        hold_run_ff;
    logic        resumed_ff;
    logic [31:0] hold_cnt_ff;
    cssc_phase_t phase_ff;
    logic [9:0]  cnt_ff;
    logic [1:0]  tag_ff;

    wire any_hold    = hold_b1_ff | hold_b2_ff;
    wire bridge_mode = (mode_ff == `CSSC_MODE_BRIDGE) && !any_hold;
    wire srst        = !resetn || soft_reset;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mode_ff    <= `CSSC_MODE_BRIDGE;
            hold_b1_ff <= 1'b0;
            hold_b2_ff <= 1'b0;
            lspar_ff   <= 2'h0;
            hspar_ff   <= 2'h0;
        end else begin
            if (frame_wr && wr_mode) begin
                mode_ff <= wr_bridge_mode_select;
            end
            if (frame_wr && wr_cfg7) begin
                hold_b1_ff <= wr_hold_enable_b1_high_pos;
                hold_b2_ff <= wr_hold_enable_b2_high_neg;
                lspar_ff   <= wr_cfg7_ls_parallel;
            end
            if (frame_wr && wr_cfg10) begin
                hspar_ff <= wr_cfg10_hs_parallel;
            end
        end
    end

    // ==========================================================
    // Stepping
    // Strobe edge judged against stored enable/direction: same-frame
    // writes of either take effect only after this frame's decision.
    wire ctrl_wr   = frame_wr && wr_ctrl;
    wire en_change = wr_enable != enable_ff;
    wire rise      = ctrl_wr && wr_strobe && !strobe_ff;
    wire do_step   = rise && enable_ff && !en_change && bridge_mode;

    cssc_phase_t nxt_phase;
    always_comb begin
        nxt_phase = phase_ff;
        case (phase_ff)
            CSSC_PP: nxt_phase = dir_ff ? CSSC_PN : CSSC_NP;
            CSSC_PN: nxt_phase = dir_ff ? CSSC_NN : CSSC_PP;
            CSSC_NN: nxt_phase = dir_ff ? CSSC_NP : CSSC_PN;
            CSSC_NP: nxt_phase = dir_ff ? CSSC_PP : CSSC_NN;
            default: nxt_phase = CSSC_PP;
        endcase
    end

    // At the limits the bridges still step; only the count stays put
    wire at_max = cnt_ff == `CSSC_CNT_MAX;
    wire at_min = cnt_ff == `CSSC_CNT_MIN;
    wire [9:0] nxt_cnt = dir_ff ? (at_max ? cnt_ff : cnt_ff + 10'h001)
                                : (at_min ? cnt_ff : cnt_ff - 10'h001);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            enable_ff <= 1'b0;
            dir_ff    <= 1'b0;
            strobe_ff <= 1'b0;
            indep_ff  <= 8'h00;
            phase_ff  <= CSSC_PP;
        end else begin
            if (ctrl_wr) begin
                enable_ff <= wr_enable;
                dir_ff    <= wr_direction;
                strobe_ff <= wr_strobe;
            end
            if (frame_wr && wr_indep) begin
                indep_ff <= wr_indep_on;
            end
            if (do_step) begin
                phase_ff <= nxt_phase;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_ff <= `CSSC_CNT_INIT;
            tag_ff <= 2'h0;
        end else if (do_step) begin
            cnt_ff <= nxt_cnt;
            tag_ff <= tag_ff + 2'h1;
        end
    end

    // Both halves read from one register pair, so the tag always matches
    assign step_count_high = {tag_ff, cnt_ff[9:5]};
    assign step_count_low  = {tag_ff, cnt_ff[4:0]};

    // ==========================================================
    // Crank hold
    // Timer starts on the host reset falling edge; any independent
    // write after reset release counts as the host taking over.
    // A second reset fall during a hold restarts the full window.
    wire rst_fall = rst_line_ff && !host_reset_line;
    wire hold_end = hold_run_ff && (hold_cnt_ff == HOLD_CYC - 1);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rst_line_ff <= 1'b0;
            hold_run_ff <= 1'b0;
            resumed_ff  <= 1'b0;
            hold_cnt_ff <= 32'h0;
        end else begin
            rst_line_ff <= host_reset_line;
            if (rst_fall && any_hold) begin
                hold_run_ff <= 1'b1;
                resumed_ff  <= 1'b0;
                hold_cnt_ff <= 32'h0;
            end else if (hold_run_ff) begin
                hold_cnt_ff <= hold_cnt_ff + 32'h1;
                if (hold_end) begin
                    hold_run_ff <= 1'b0;
                end
                if (host_reset_line && frame_wr && wr_indep) begin
                    resumed_ff <= 1'b1;
                end
            end
        end
    end

    // Until the host resumes, held stages stay on; after expiry they follow the command
    wire keep_b1 = hold_run_ff && !resumed_ff && hold_b1_ff;
    wire keep_b2 = hold_run_ff && !resumed_ff && hold_b2_ff;

    // ==========================================================
    // Output selection
    wire b1_neg = (phase_ff == CSSC_NN) || (phase_ff == CSSC_NP);
    wire b2_neg = (phase_ff == CSSC_PN) || (phase_ff == CSSC_NN);
    wire br_on  = bridge_mode && enable_ff;
    wire [3:0] br1;
    wire [3:0] br2;

    cssc_bridge u_br1 (
        .drive_on  (br_on),
        .state_neg (b1_neg),
        .hs_pos    (br1[0]),
        .ls_pos    (br1[1]),
        .hs_neg    (br1[2]),
        .ls_neg    (br1[3])
    );
    cssc_bridge u_br2 (
        .drive_on  (br_on),
        .state_neg (b2_neg),
        .hs_pos    (br2[0]),
        .ls_pos    (br2[1]),
        .hs_neg    (br2[2]),
        .ls_neg    (br2[3])
    );

    // Independent bit order: 0 b1_hs_pos,1 b1_ls_neg,2 b1_hs_neg,3 b1_ls_pos,
    // 4 b2_hs_neg,5 b2_hs_pos,6 b2_ls_pos,7 b2_ls_neg. No pair coherency check.
    wire [7:0] ind = indep_ff;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            b1_hs_pos <= 1'b0;
            b1_ls_neg <= 1'b0;
            b1_hs_neg <= 1'b0;
            b1_ls_pos <= 1'b0;
            b2_hs_neg <= 1'b0;
            b2_hs_pos <= 1'b0;
            b2_ls_pos <= 1'b0;
            b2_ls_neg <= 1'b0;
        end else if (bridge_mode) begin
            b1_hs_pos <= br1[0];
            b1_ls_pos <= br1[1];
            b1_hs_neg <= br1[2];
            b1_ls_neg <= br1[3];
            b2_hs_pos <= br2[0];
            b2_ls_pos <= br2[1];
            b2_hs_neg <= br2[2];
            b2_ls_neg <= br2[3];
        end else begin
            b1_hs_pos <= ind[0] | keep_b1;
            b1_ls_neg <= ind[1];
            b1_hs_neg <= ind[2];
            b1_ls_pos <= ind[3];
            b2_hs_neg <= ind[4] | keep_b2;
            b2_hs_pos <= ind[5];
            b2_ls_pos <= ind[6];
            b2_ls_neg <= ind[7];
        end
    end

    assign bridge_active = bridge_mode;
    assign hold_active   = hold_run_ff;
    assign ls_parallel   = lspar_ff;
    assign hs_parallel   = hspar_ff;

    // ==========================================================
    // Checks
    // Switches are registered: leg checks use the mode that launched them
    bridge_legs_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        $past(bridge_mode) |->
        (!(b1_hs_pos && b1_ls_neg) && !(b1_hs_neg && b1_ls_pos) &&
        !(b2_hs_pos && b2_ls_neg) && !(b2_hs_neg && b2_ls_pos)))
        else $error("bridge leg shoot-through");
    disabled_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (bridge_mode && !enable_ff) |=> !(b1_hs_pos | b1_hs_neg | b2_hs_pos | b2_hs_neg))
        else $error("bridge on while disabled");
    hold_forces_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        any_hold |-> !bridge_active ##1
            ({b2_ls_neg, b2_ls_pos, b2_hs_pos, b1_ls_pos, b1_hs_neg, b1_ls_neg} ==
             $past({indep_ff[7:5], indep_ff[3:1]})))
        else $error("bridge mode despite hold enable");
    step_once_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (phase_ff != $past(phase_ff)) |-> $past(do_step))
        else $error("phase moved without step");
    same_frame_en_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (ctrl_wr && en_change) |=> $stable(phase_ff))
        else $error("strobe acted with enable change");
    cnt_sat_a: assert property (@(posedge sys_clk) disable iff (srst)
        (do_step && at_max && dir_ff) |=> cnt_ff == `CSSC_CNT_MAX)
        else $error("counter wrapped at max");
    cnt_dir_a: assert property (@(posedge sys_clk) disable iff (srst)
        (do_step && !dir_ff && !at_min) |=> cnt_ff == $past(cnt_ff) - 10'h001)
        else $error("counter not decremented");
    cnt_init_a: assert property (@(posedge sys_clk)
        srst |=> cnt_ff == `CSSC_CNT_INIT)
        else $error("counter not reset to 512");
    tag_match_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        step_count_high[6:5] == step_count_low[6:5])
        else $error("step tags differ");
    dir_cycle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (do_step && dir_ff && phase_ff == CSSC_PP) |=> phase_ff == CSSC_PN)
        else $error("wrong step order");
    cnt_up_a: assert property (@(posedge sys_clk) disable iff (srst)
        (do_step && dir_ff && !at_max) |=> cnt_ff == $past(cnt_ff) + 10'h001)
        else $error("counter not incremented");
    strobe_low_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (ctrl_wr && !wr_strobe) |=> $stable(phase_ff))
        else $error("strobe low moved the bridges");
    idle_strobe_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (ctrl_wr && wr_strobe && !enable_ff) |=> $stable(phase_ff))
        else $error("step taken while disabled");
    dir_back_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (do_step && !dir_ff && phase_ff == CSSC_PP) |=> phase_ff == CSSC_NP)
        else $error("wrong reverse step order");
    hold_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (keep_b1 || keep_b2) |=>
        ((b1_hs_pos || !$past(keep_b1)) && (b2_hs_neg || !$past(keep_b2))))
        else $error("held stage dropped during crank hold");

    // ==========================================================
    // Coverage
    step_cov_c:   cover property (@(posedge sys_clk) do_step);
    hold_cov_c:   cover property (@(posedge sys_clk) hold_end);
    sat_cov_c:    cover property (@(posedge sys_clk) do_step && at_min && !dir_ff);
    resume_cov_c: cover property (@(posedge sys_clk) hold_run_ff && resumed_ff);
    indep_cov_c:  cover property (@(posedge sys_clk) !bridge_mode && frame_wr && wr_indep);
endmodule : cssc_ctrl

// [rtl/cssc_pkg.sv]
package cssc_pkg;
    typedef enum logic [1:0] {
        CSSC_PP,
        CSSC_PN,
        CSSC_NN,
        CSSC_NP
    } cssc_phase_t;
endpackage : cssc_pkg

// [rtl/cssc_regs.svh]
`ifndef CSSC_REGS_SVH
`define CSSC_REGS_SVH
// Step counter
`define CSSC_CNT_W        10
`define CSSC_HALF_W       5
`define CSSC_CNT_INIT     10'h200
`define CSSC_CNT_MAX      10'h3FF
`define CSSC_CNT_MIN      10'h000
// Crank hold timing (hold window 400..800 ms, choose nominal 600)
`define CSSC_HOLD_MS      600
`define CSSC_CLK_MHZ      250
`define CSSC_HOLD_CYC     (`CSSC_HOLD_MS * 1000 * `CSSC_CLK_MHZ)
// Mode select encodings
`define CSSC_MODE_BRIDGE  2'h0
`endif

// [testbench/config_stage_stepper_ctrl_tb.sv]
`timescale 1ns/10ps
// ==========================================================
// Bench for the configurable stage stepper control
module config_stage_stepper_ctrl_tb;
    localparam int HOLD = 60;
    logic       sys_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       soft_reset = 1'b0;
    wire        frame_wr, wr_ctrl, wr_enable, wr_direction, wr_strobe, wr_indep, wr_mode, wr_cfg7, wr_cfg10;
    wire  [7:0] wr_indep_on;
    wire  [1:0] wr_bridge_mode_select, wr_cfg7_ls_parallel, wr_cfg10_hs_parallel, ls_parallel, hs_parallel;
    wire        wr_hold_enable_b1_high_pos, wr_hold_enable_b2_high_neg, host_reset_line;
    wire        b1_hs_pos, b1_ls_neg, b1_hs_neg, b1_ls_pos, b2_hs_neg, b2_hs_pos, b2_ls_pos, b2_ls_neg;
    wire        bridge_active, hold_active;
    wire  [6:0] step_count_high, step_count_low;
    wire  [7:0] sw = {b2_ls_neg, b2_ls_pos, b2_hs_pos, b2_hs_neg, b1_ls_pos, b1_hs_neg, b1_ls_neg, b1_hs_pos};
    int         fails = 0;
    int         compares = 0;
    int         n;
    logic [31:0] r;
    logic [9:0] cnt;
    logic [1:0] tag, ph;
    logic       sen, sdir, sstb;

    always #2 sys_clk = ~sys_clk;

    cssc_host HOST (.sys_clk(sys_clk), .frame_wr(frame_wr), .wr_ctrl(wr_ctrl), .wr_enable(wr_enable),
        .wr_direction(wr_direction), .wr_strobe(wr_strobe), .wr_indep(wr_indep), .wr_indep_on(wr_indep_on),
        .wr_mode(wr_mode), .wr_bridge_mode_select(wr_bridge_mode_select), .wr_cfg7(wr_cfg7),
        .wr_hold_enable_b1_high_pos(wr_hold_enable_b1_high_pos),
        .wr_hold_enable_b2_high_neg(wr_hold_enable_b2_high_neg),
        .wr_cfg7_ls_parallel(wr_cfg7_ls_parallel), .wr_cfg10(wr_cfg10), .wr_cfg10_hs_parallel(wr_cfg10_hs_parallel),
        .host_reset_line(host_reset_line));

    cssc_ctrl #(.HOLD_CYC(HOLD)) DUT (.sys_clk(sys_clk), .resetn(resetn), .soft_reset(soft_reset),
        .frame_wr(frame_wr), .wr_ctrl(wr_ctrl), .wr_enable(wr_enable), .wr_direction(wr_direction),
        .wr_strobe(wr_strobe), .wr_indep(wr_indep), .wr_indep_on(wr_indep_on), .wr_mode(wr_mode),
        .wr_bridge_mode_select(wr_bridge_mode_select), .wr_cfg7(wr_cfg7),
        .wr_hold_enable_b1_high_pos(wr_hold_enable_b1_high_pos),
        .wr_hold_enable_b2_high_neg(wr_hold_enable_b2_high_neg),
        .wr_cfg7_ls_parallel(wr_cfg7_ls_parallel), .wr_cfg10(wr_cfg10), .wr_cfg10_hs_parallel(wr_cfg10_hs_parallel),
        .host_reset_line(host_reset_line), .b1_hs_pos(b1_hs_pos), .b1_ls_neg(b1_ls_neg), .b1_hs_neg(b1_hs_neg),
        .b1_ls_pos(b1_ls_pos), .b2_hs_neg(b2_hs_neg), .b2_hs_pos(b2_hs_pos), .b2_ls_pos(b2_ls_pos),
        .b2_ls_neg(b2_ls_neg), .bridge_active(bridge_active), .hold_active(hold_active),
        .ls_parallel(ls_parallel), .hs_parallel(hs_parallel), .step_count_high(step_count_high),
        .step_count_low(step_count_low));

    // ==========================================================
    // Expectation model
    function automatic logic [7:0] exp_sw(input logic en, input logic [1:0] p);
        logic n1, n2;
        n1 = p[1];
        n2 = (p == 2'h1) || (p == 2'h2);
        if (!en) return 8'h00;
        return {n2, ~n2, ~n2, n2, ~n1, n1, n1, ~n1};
    endfunction : exp_sw

    // An enable change swallows the strobe; a step uses the direction stored before this frame
    function automatic void model(input logic en, input logic dir, input logic stb);
        if (en !== sen) sen = en;
        else if (en && stb && !sstb) begin
            ph = sdir ? ph + 2'h1 : ph - 2'h1;
            tag = tag + 2'h1;
            if (sdir) cnt = (cnt == 10'h3FF) ? cnt : cnt + 10'h001;
            else cnt = (cnt == 10'h000) ? cnt : cnt - 10'h001;
        end
        sdir = dir;
        sstb = stb;
    endfunction : model

    // ==========================================================
    // Tasks
    task automatic results();
        if (fails == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wt(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : wt

    task automatic ctrl(input logic en, input logic dir, input logic stb);
        HOST.send(5'h01, {5'h00, stb, dir, en});
        model(en, dir, stb);
        wt(3);
    endtask : ctrl

    task automatic chk_all();
        chk({8'h00, sw}, {8'h00, exp_sw(sen, ph)});
        chk({2'h0, step_count_high, step_count_low}, {2'h0, tag, cnt[9:5], tag, cnt[4:0]});
    endtask : chk_all

    task automatic chk_cnt(input logic [9:0] e);
        chk({6'h00, step_count_high[4:0], step_count_low[4:0]}, {6'h00, e});
        chk({14'h0000, step_count_high[6:5]}, {14'h0000, step_count_low[6:5]});
    endtask : chk_cnt

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(42806));
        {sen, sdir, sstb, ph, tag, cnt} = {3'h0, 2'h0, 2'h0, 10'h200};
        wt(2);
        resetn = 1'b1;
        wt(1);
        chk_all();
        chk({15'h0000, bridge_active}, 16'h0001);
        ctrl(1'b0, 1'b1, 1'b1); chk_all();
        ctrl(1'b1, 1'b1, 1'b0); chk_all();
        ctrl(1'b0, 1'b1, 1'b1); chk_all();
        ctrl(1'b1, 1'b0, 1'b0); ctrl(1'b1, 1'b1, 1'b1); chk_all();
        // Mostly enabled random frames, with direction and strobe mixed freely
        for (int i = 0; i < 300; i++) begin
            r = $urandom;
            ctrl(r[3:0] != 4'h0, r[4], r[5]);
            chk_all();
        end
        // Saturation at the top, soft reset, then saturation at the bottom
        // Enough steps to reach the top from anywhere the random phase can leave the count
        repeat (680) begin ctrl(1'b1, 1'b1, 1'b0); ctrl(1'b1, 1'b1, 1'b1); end
        chk_cnt(10'h3FF);
        soft_reset = 1'b1;
        wt(1);
        soft_reset = 1'b0;
        {cnt, tag} = {10'h200, 2'h0};
        wt(2);
        chk_all();
        repeat (520) begin ctrl(1'b1, 1'b0, 1'b0); ctrl(1'b1, 1'b0, 1'b1); end
        chk_cnt(10'h000);
        // Independent stages, paired low sides commanded alike
        for (int m = 1; m < 4; m++) begin
            HOST.send(5'h04, 8'(m));
            repeat (6) begin
                r = $urandom;
                r[3] = r[1];
                r[7] = r[6];
                HOST.send(5'h02, r[7:0]);
                wt(2);
                chk({7'h00, bridge_active, sw}, {8'h00, r[7:0]});
            end
        end
        // Crank hold with only the first high-side hold enable, mode bits still at bridges
        HOST.send(5'h04, 8'h00);
        HOST.send(5'h02, 8'h00);
        HOST.send(5'h08, 8'h09);
        HOST.send(5'h10, 8'h01);
        wt(2);
        chk({3'h0, bridge_active, ls_parallel, hs_parallel, sw}, 16'h0900);
        HOST.set_rst(1'b0);
        wt(2);
        chk({7'h00, hold_active, sw}, 16'h0101);
        n = 2;
        while (b1_hs_pos === 1'b1 && n < 200) begin n++; wt(1); end
        if (n >= 200) begin fails++; results(); end
        chk({15'h0000, n >= HOLD * 2 / 3 && n <= HOLD * 4 / 3}, 16'h0001);
        wt(2);
        chk({7'h00, hold_active, sw}, 16'h0000);
        // Both enables set, then the host resumes control before expiry
        HOST.send(5'h08, 8'h03);
        HOST.set_rst(1'b1);
        HOST.set_rst(1'b0);
        wt(3);
        chk({8'h00, sw}, 16'h0011);
        HOST.set_rst(1'b1);
        HOST.send(5'h02, 8'h20);
        wt(2);
        chk({7'h00, hold_active, sw}, 16'h0120);
        wt(2 * HOLD);
        chk({7'h00, hold_active, sw}, 16'h0020);
        results();
    end
endmodule : config_stage_stepper_ctrl_tb

// [testbench/cssc_host.sv]
`timescale 1ns/10ps
// ==========================================================
// Host controller model: sends control frames, drives reset line
module cssc_host (
    // Clock
    input  wire logic       sys_clk,
    // Frame port
    output logic            frame_wr,
    output logic            wr_ctrl,
    output logic            wr_enable,
    output logic            wr_direction,
    output logic            wr_strobe,
    output logic            wr_indep,
    output logic [7:0]      wr_indep_on,
    output logic            wr_mode,
    output logic [1:0]      wr_bridge_mode_select,
    output logic            wr_cfg7,
    output logic            wr_hold_enable_b1_high_pos,
    output logic            wr_hold_enable_b2_high_neg,
    output logic [1:0]      wr_cfg7_ls_parallel,
    output logic            wr_cfg10,
    output logic [1:0]      wr_cfg10_hs_parallel,
    // Host reset line
    output logic            host_reset_line
);
    task automatic put(input logic [4:0] grp, input logic [7:0] d);
        {wr_cfg10, wr_cfg7, wr_mode, wr_indep, wr_ctrl} = grp;
        {wr_strobe, wr_direction, wr_enable} = d[2:0];
        wr_indep_on = d;
        wr_bridge_mode_select = d[1:0];
        {wr_cfg7_ls_parallel, wr_hold_enable_b2_high_neg, wr_hold_enable_b1_high_pos} = d[3:0];
        wr_cfg10_hs_parallel = d[1:0];
    endtask : put

    // Fields are only qualified by frame_wr, so they are scrambled afterwards
    task automatic send(input logic [4:0] grp, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        frame_wr = 1'b1;
        put(grp, d);
        @(posedge sys_clk);
        #1;
        frame_wr = 1'b0;
        put(5'h00, ~d);
    endtask : send

    task automatic set_rst(input logic v);
        @(posedge sys_clk);
        #1;
        host_reset_line = v;
    endtask : set_rst

    initial begin
        frame_wr = 1'b0;
        host_reset_line = 1'b1;
        put(5'h00, 8'h00);
    end
endmodule : cssc_host
